/* logic/pfps_defs.svh */
// Timing and pulse count constants for the pin fault protection supervisor.
`ifndef PFPS_DEFS_SVH
`define PFPS_DEFS_SVH
`define PFPS_CLK_MHZ          200
`define PFPS_LIMIT_LONG_NS    2000
`define PFPS_LIMIT_SHORT_NS   1000
`define PFPS_LIMIT_LONG_CYC   ((`PFPS_LIMIT_LONG_NS * `PFPS_CLK_MHZ) / 1000)
`define PFPS_LIMIT_SHORT_CYC  ((`PFPS_LIMIT_SHORT_NS * `PFPS_CLK_MHZ) / 1000)
`define PFPS_BIAS_CHECK_NS    10000
`define PFPS_BIAS_CHECK_CYC   ((`PFPS_BIAS_CHECK_NS * `PFPS_CLK_MHZ) / 1000)
`define PFPS_RESTART_MS       1500
`define PFPS_RESTART_CYC      (`PFPS_RESTART_MS * 1000 * `PFPS_CLK_MHZ)
`define PFPS_CONSEC_PULSES    3
`endif

/* logic/pfps_pkg.sv */
// Types for the pin fault protection supervisor.
package pfps_pkg;
  typedef enum logic [2:0] {
    PFPS_IDLE    = 3'h0,
    PFPS_WAIT    = 3'h1,
    PFPS_RUN     = 3'h2,
    PFPS_RESTART = 3'h3,
    PFPS_UVLO    = 3'h4
  } pfps_state_t;
endpackage

/* logic/pfps_supervisor.sv */
// Pin fault protection supervisor: start-up checks, pulse checks and fault responses.
`include "pfps_defs.svh"
// Overview of operation
// - Time first gate pulse, 2 us limit.
// - Select low: demag picks 2 or 1 us.
// - Sense short: stop, 1.5 s, auto restart.
// - Overcurrent three pulses: open fault, restart.
// - No switching before bias pin check passes.
// - At 10 us, bias low: one UVLO cycle.
// - Bias overvoltage three pulses: one UVLO cycle.
// - Program pins: low current open, high short.
// - Program fault blocks switching, one UVLO cycle.
module pfps_supervisor #(
  parameter int RESTART_CYC = `PFPS_RESTART_CYC
) (
  input  wire logic REF_CLK_I,       // 200 MHz controller clock.
  input  wire logic RST_I,           // Synchronous reset, active high.
  input  wire logic SUPPLY_ON_I,     // Supply reached turn-on level (start-up event).
  input  wire logic GATE_REQ_I,      // Low side gate pulse request from the loop.
  input  wire logic SELECT_I,        // Power device select level.
  input  wire logic DEMAG_HIGH_I,    // Demag resistance above its threshold.
  input  wire logic OVERCUR_I,       // Sense voltage above overcurrent threshold.
  input  wire logic BIAS_LOW_I,      // Bias regulator pin below 14 V.
  input  wire logic BIAS_OV_I,       // Bias regulator pin above 15 V.
  input  wire logic DEMAG_OPEN_I,    // Demag pin current too small.
  input  wire logic DEMAG_SHORT_I,   // Demag pin current too large.
  input  wire logic ZVS_OPEN_I,      // ZVS timing pin current too small.
  input  wire logic ZVS_SHORT_I,     // ZVS timing pin current too large.
  output logic      GATE_O,          // Low side gate pulse, gated by faults.
  output logic      SWITCH_EN_O,     // Switching permitted.
  output logic      UVLO_REQ_O,      // Request one undervoltage lockout cycle.
  output logic      RESTART_BUSY_O,  // Fault restart delay running.
  output logic      FAULT_SHORT_O,   // Sense pin short latched.
  output logic      FAULT_OPEN_O,    // Sense pin open latched.
  output logic      FAULT_BIAS_O,    // Bias pin fault latched.
  output logic      FAULT_PROG_O     // Programming pin fault latched.
);
  localparam int LONG_CYC  = `PFPS_LIMIT_LONG_CYC;
  localparam int SHORT_CYC = `PFPS_LIMIT_SHORT_CYC;
  localparam int CHECK_CYC = `PFPS_BIAS_CHECK_CYC;
  localparam logic [1:0] CONSEC_LAST = 2'(`PFPS_CONSEC_PULSES - 1);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [10:0] sync_in;
  logic        s_on, s_req, s_sel, s_dh, s_oc, s_bl, s_bov, s_do, s_ds, s_zo, s_zs;

  pfps_sync #(.W(11)) u_sync (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .d_i   ({SUPPLY_ON_I, GATE_REQ_I, SELECT_I, DEMAG_HIGH_I, OVERCUR_I, BIAS_LOW_I,
             BIAS_OV_I, DEMAG_OPEN_I, DEMAG_SHORT_I, ZVS_OPEN_I, ZVS_SHORT_I}),
    .q_o   (sync_in)
  );
  assign {s_on, s_req, s_sel, s_dh, s_oc, s_bl, s_bov, s_do, s_ds, s_zo, s_zs} = sync_in;

  function automatic logic [1:0] pulse_count(input logic [1:0] c, input logic cond);
    pulse_count = cond ? ((c == 2'h3) ? 2'h3 : c + 2'h1) : 2'h0;
  endfunction

  // ---------------------------------------------------------------
  // Supervisor state
  // ---------------------------------------------------------------
  pfps_pkg::pfps_state_t state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [1:0]  oc_cnt, next_oc_cnt, ov_cnt, next_ov_cnt;
  logic        first_done, next_first_done;
  logic        on_q, next_on_q;
  logic        gate, next_gate;
  logic        f_short, f_open, f_bias, f_prog;
  logic        next_f_short, next_f_open, next_f_bias, next_f_prog;
  logic        uvlo, next_uvlo;
  logic        run_gate;
  logic        pulse_end;
  logic [31:0] limit;

  assign run_gate  = (state == pfps_pkg::PFPS_RUN) && s_req;
  assign pulse_end = gate && !run_gate;
  assign limit     = (s_sel || s_dh) ? 32'(LONG_CYC) : 32'(SHORT_CYC);

  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_oc_cnt     = oc_cnt;
    next_ov_cnt     = ov_cnt;
    next_first_done = first_done;
    next_on_q       = s_on;
    next_gate       = 1'b0;
    next_f_short    = f_short;
    next_f_open     = f_open;
    next_f_bias     = f_bias;
    next_f_prog     = f_prog;
    next_uvlo       = 1'b0;
    case (state)
      pfps_pkg::PFPS_IDLE:
      begin
        if (s_on && !on_q)
        begin
          next_state      = pfps_pkg::PFPS_WAIT;
          next_cnt        = 32'h0;
          next_oc_cnt     = 2'h0;
          next_ov_cnt     = 2'h0;
          next_first_done = 1'b0;
          next_f_short    = 1'b0;
          next_f_open     = 1'b0;
          next_f_bias     = 1'b0;
          next_f_prog     = 1'b0;
        end
      end
      pfps_pkg::PFPS_WAIT:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt == 32'(CHECK_CYC - 1))
        begin
          if (s_do || s_ds || s_zo || s_zs)
          begin
            next_f_prog = 1'b1;
            next_state  = pfps_pkg::PFPS_UVLO;
          end
          else if (s_bl)
          begin
            next_f_bias = 1'b1;
            next_state  = pfps_pkg::PFPS_UVLO;
          end
          else
          begin
            next_state = pfps_pkg::PFPS_RUN;
            next_cnt   = 32'h0;
          end
        end
      end
      pfps_pkg::PFPS_RUN:
      begin
        next_gate = run_gate;
        if (gate && !first_done)
          next_cnt = cnt + 32'h1;
        if (pulse_end)
        begin
          next_first_done = 1'b1;
          next_oc_cnt     = pulse_count(oc_cnt, s_oc);
          next_ov_cnt     = pulse_count(ov_cnt, s_bov);
        end
        if (gate && !first_done && cnt + 32'h1 >= limit)
        begin
          next_f_short = 1'b1;
          next_gate    = 1'b0;
          next_state   = pfps_pkg::PFPS_RESTART;
          next_cnt     = 32'h0;
        end
        else if (pulse_end && s_oc && oc_cnt == CONSEC_LAST)
        begin
          next_f_open = 1'b1;
          next_state  = pfps_pkg::PFPS_RESTART;
          next_cnt    = 32'h0;
        end
        else if (pulse_end && s_bov && ov_cnt == CONSEC_LAST)
        begin
          next_f_bias = 1'b1;
          next_gate   = 1'b0;
          next_state  = pfps_pkg::PFPS_UVLO;
        end
        else if (!s_on)
          next_state = pfps_pkg::PFPS_IDLE;
      end
      pfps_pkg::PFPS_RESTART:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt == 32'(RESTART_CYC - 1))
          next_state = pfps_pkg::PFPS_UVLO;
      end
      pfps_pkg::PFPS_UVLO:
      begin
        next_uvlo = 1'b1;
        if (!s_on)
          next_state = pfps_pkg::PFPS_IDLE;
      end
      default:
        next_state = pfps_pkg::PFPS_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      state      <= pfps_pkg::PFPS_IDLE;
      cnt        <= 32'h0;
      oc_cnt     <= 2'h0;
      ov_cnt     <= 2'h0;
      first_done <= 1'b0;
      on_q       <= 1'b0;
      gate       <= 1'b0;
      f_short    <= 1'b0;
      f_open     <= 1'b0;
      f_bias     <= 1'b0;
      f_prog     <= 1'b0;
      uvlo       <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      oc_cnt     <= next_oc_cnt;
      ov_cnt     <= next_ov_cnt;
      first_done <= next_first_done;
      on_q       <= next_on_q;
      gate       <= next_gate;
      f_short    <= next_f_short;
      f_open     <= next_f_open;
      f_bias     <= next_f_bias;
      f_prog     <= next_f_prog;
      uvlo       <= next_uvlo;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic sw_en, busy;
  logic next_sw_en, next_busy;
  always_comb
  begin
    next_sw_en = (next_state == pfps_pkg::PFPS_RUN);
    next_busy  = (next_state == pfps_pkg::PFPS_RESTART);
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      sw_en <= 1'b0;
      busy  <= 1'b0;
    end
    else
    begin
      sw_en <= next_sw_en;
      busy  <= next_busy;
    end
  end

  assign GATE_O         = gate;
  assign SWITCH_EN_O    = sw_en;
  assign UVLO_REQ_O     = uvlo;
  assign RESTART_BUSY_O = busy;
  assign FAULT_SHORT_O  = f_short;
  assign FAULT_OPEN_O   = f_open;
  assign FAULT_BIAS_O   = f_bias;
  assign FAULT_PROG_O   = f_prog;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  no_early_gate_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    gate |-> $past(state) == pfps_pkg::PFPS_RUN)
    else $error("Gate pulse outside run state.");
  first_limit_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state == pfps_pkg::PFPS_RUN && !first_done && gate && s_sel
     && cnt == 32'(LONG_CYC - 1)) |=> f_short && !gate)
    else $error("First pulse not cut at long limit.");
  short_limit_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state == pfps_pkg::PFPS_RUN && !first_done && gate && !s_sel && !s_dh
     && cnt == 32'(SHORT_CYC - 1)) |=> f_short && !gate)
    else $error("First pulse not cut at short limit.");
  restart_time_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state == pfps_pkg::PFPS_RESTART) |-> !gate)
    else $error("Gate during restart delay.");
  open_three_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(f_open) |-> $past(oc_cnt) == 2'h2)
    else $error("Open fault without three pulses.");
  bias_ov_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (f_bias && $past(state) == pfps_pkg::PFPS_RUN && !$past(f_bias))
    |-> state == pfps_pkg::PFPS_UVLO)
    else $error("Bias overvoltage without lockout.");
  prog_fault_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(f_prog) |-> state == pfps_pkg::PFPS_UVLO ##1 uvlo)
    else $error("Program pin fault without lockout.");
  clear_start_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state == pfps_pkg::PFPS_IDLE && next_state == pfps_pkg::PFPS_WAIT)
    |=> !f_short && !f_open && oc_cnt == 2'h0)
    else $error("Latches not cleared at start-up.");
  bias_check_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state == pfps_pkg::PFPS_WAIT && next_state == pfps_pkg::PFPS_RUN)
    |-> cnt == 32'(CHECK_CYC - 1) && !s_bl)
    else $error("Run entered without bias check.");
endmodule

/* logic/pfps_sync.sv */
// Two flip-flop synchroniser for a bus of comparator levels.
module pfps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // Clock.
  input  wire logic         rst_i,  // Synchronous reset.
  input  wire logic [W-1:0] d_i,    // Asynchronous levels.
  output logic      [W-1:0] q_o     // Synchronised levels.
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* verif/pfps_stage_model.sv */
// Power stage model: comparator levels that the supervisor senses.
module pfps_stage_model (
  input  wire logic       clk_i,   // Controller clock.
  input  wire logic [6:0] mode_i,  // Fault modes chosen by the bench.
  output logic      [6:0] cmp_o    // Comparator levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bits: overcurrent, bias over, bias low, demag open, demag short, zvs open, zvs short.
  always_ff @(posedge clk_i)
  begin
    cmp_o <= mode_i;
  end
endmodule

/* verif/test_pin_fault_protection_supervisor.sv */
// Self-checking bench for the pin fault protection supervisor.
module test_pin_fault_protection_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 1000;
  logic       clk = 0, rst = 1, sup = 0, req = 0, sel = 0, dh = 0;
  logic [6:0] mode = 0, cmp;
  logic       gate, sw_en, uvlo, busy, f_sh, f_op, f_bi, f_pr;
  int         n_errors = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pfps_stage_model model (.clk_i(clk), .mode_i(mode), .cmp_o(cmp));
  pfps_supervisor #(.RESTART_CYC(RC)) DUT (
    .REF_CLK_I(clk), .RST_I(rst), .SUPPLY_ON_I(sup), .GATE_REQ_I(req),
    .SELECT_I(sel), .DEMAG_HIGH_I(dh), .OVERCUR_I(cmp[0]), .BIAS_OV_I(cmp[1]),
    .BIAS_LOW_I(cmp[2]), .DEMAG_OPEN_I(cmp[3]), .DEMAG_SHORT_I(cmp[4]),
    .ZVS_OPEN_I(cmp[5]), .ZVS_SHORT_I(cmp[6]), .GATE_O(gate), .SWITCH_EN_O(sw_en),
    .UVLO_REQ_O(uvlo), .RESTART_BUSY_O(busy), .FAULT_SHORT_O(f_sh),
    .FAULT_OPEN_O(f_op), .FAULT_BIAS_O(f_bi), .FAULT_PROG_O(f_pr));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int n);
    req = 1;
    tick(n);
    req = 0;
    tick(10);
  endtask
  // New supply cycle; switching must wait for the start-up checks.
  task automatic power_up(input logic [6:0] m, input logic run);
    mode = m;
    sup = 0;
    tick(6);
    sup = 1;
    tick(4);
    check(|{f_sh, f_op, f_bi, f_pr}, 0);
    tick(1985);
    check(sw_en, 0);
    tick(25);
    check(sw_en, run);
    check(uvlo, !run);
  endtask
  // First pulse held until the device cuts it.
  task automatic first_pulse_cut(input logic s, input logic d);
    int lim;
    int cnt;
    sel = s;
    dh = d;
    lim = (s | d) ? 400 : 200;
    cnt = 0;
    power_up(0, 1);
    req = 1;
    repeat (700)
    begin
      tick(1);
      cnt += gate;
    end
    req = 0;
    check(cnt >= lim - 4 && cnt <= lim + 4, 1);
    check(f_sh, 1);
    check(busy, 1);
    check(sw_en, 0);
    tick(RC + 10);
    check(busy, 0);
    check(uvlo, 1);
  endtask
  // Three consecutive pulses with a condition; a clean pulse restarts the count.
  task automatic three_pulses(input int b);
    sel = 0;
    dh = 0;
    power_up(0, 1);
    pulse(20);
    pulse(300);
    check(f_sh, 0);
    mode[b] = 1;
    pulse(20);
    pulse(20);
    mode[b] = 0;
    tick(10);
    pulse(20);
    mode[b] = 1;
    tick(10);
    pulse(20);
    pulse(20);
    check(b ? f_bi : f_op, 0);
    pulse(20);
    check(b ? f_bi : f_op, 1);
    check(b ? uvlo : busy, 1);
    mode[b] = 0;
    tick(RC + 10);
    check(uvlo, 1);
  endtask
  // Start-up pin faults must block switching even while pulses are requested.
  task automatic start_up_faults();
    req = 1;
    power_up(7'h04, 0);
    check(f_bi, 1);
    check(gate, 0);
    for (int i = 3; i < 7; i++)
    begin
      power_up(7'h01 << i, 0);
      check(f_pr, 1);
      check(gate, 0);
    end
    req = 0;
    power_up(0, 1);
  endtask
  initial
  begin
    tick(4);
    rst = 0;
    tick(2);
    for (int k = 0; k < 3; k++)
      first_pulse_cut(k == 0, k == 1);
    three_pulses(0);
    three_pulses(1);
    start_up_faults();
    end_of_test();
  end
endmodule
